// file: inc/mem_port_map.vh
`ifndef MEM_PORT_MAP_VH
`define MEM_PORT_MAP_VH

// control port bits and state after reset (both groups enabled)
`define MAP_GRP0_BIT 6
`define MAP_GRP1_BIT 7
`define MAP_RESET_VAL 2'b00
`define MAP_READ_VAL 2'b11
`define MAP_DELAY_CYCLES 2'd3

// memory windows, compared on the upper address bits
`define LOW_ROM_TOP5 5'h00
`define HIGH_ROM_TOP5 5'h1b
`define GRP1_TOP4 4'hd
`define SHADOW_TOP5 5'h1a
`define RAM_TOP8 8'hd0
`define TIMER_TOP14 14'h3440
`define ROM_WIN_BITS 11

// i/o port addresses
`define IO_MAP_CTRL 8'hf3
`define IO_PAR_DATA 8'h14
`define IO_PAR_STAT 8'h15
`define IO_SER_DATA 8'h12
`define IO_SER_STAT 8'h13
`define IO_SER_DATA2 8'h04
`define IO_SER_STAT2 8'h05
`define IO_ALIAS_DATA 8'h02
`define IO_ALIAS_STAT 8'h03

// value returned where nothing on the card drives the bus
`define IDLE_READ 8'hff

`endif

// file: hw/scratch_ram.v
`timescale 1ns/1ps
`default_nettype none

module scratch_ram #(
  parameter AW = 8,
  parameter DW = 8
) (
  input wire clk_i,
  input wire we_i,
  input wire [AW-1:0] addr_i,
  input wire [DW-1:0] wdata_i,
  output reg [DW-1:0] rdata_o
);

  // storage has no reset so contents survive map changes and resets
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // synchronous write, registered read
  always @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    rdata_o <= mem[addr_i];
  end

endmodule

`default_nettype wire

// file: hw/map_control.v
`timescale 1ns/1ps
`default_nettype none
`include "mem_port_map.vh"

module map_control (
  input wire clk_i,
  input wire rst_i,
  input wire load_i,
  input wire [1:0] load_val_i,
  input wire cycle_i,
  output reg [1:0] map_o,
  output reg pending_o
);

  reg [1:0] next_q;
  reg [1:0] count_q;

  // new value waits for three processor cycles, then takes effect
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      map_o <= `MAP_RESET_VAL;
      next_q <= `MAP_RESET_VAL;
      count_q <= 2'd0;
      pending_o <= 1'b0;
    end else if (load_i) begin
      // a later command restarts the wait
      next_q <= load_val_i;
      count_q <= 2'd0;
      pending_o <= 1'b1;
    end else if (pending_o && cycle_i) begin
      if (count_q == `MAP_DELAY_CYCLES - 2'd1) begin
        map_o <= next_q;
        pending_o <= 1'b0;
        count_q <= 2'd0;
      end else begin
        count_q <= count_q + 2'd1;
      end
    end
  end

endmodule

`default_nettype wire

// file: hw/memory_port_decode.v
`timescale 1ns/1ps
`default_nettype none
`include "mem_port_map.vh"

module memory_port_decode #(
  parameter ROM_AW = 11,
  parameter RAM_AW = 8
) (
  // clock and reset
  input wire CORE_CLK_I,
  input wire RST_I,
  // processor cycles, strobes are one-cycle pulses
  input wire [15:0] ADDR_I,
  input wire [7:0] DATA_I,
  input wire MEM_RD_I,
  input wire MEM_WR_I,
  input wire IO_RD_I,
  input wire IO_WR_I,
  input wire CPU_CYCLE_I,
  // option switches
  input wire PAR_CONSOLE_ALIAS_I,
  input wire SER_CONSOLE_ALIAS_I,
  input wire ROM_1K_I,
  // data returned by the attached functions
  input wire [7:0] ROM_DATA_I,
  input wire [7:0] TIMER_DATA_I,
  input wire [7:0] PAR_DATA_I,
  input wire [5:0] PAR_STATUS_I,
  input wire [7:0] SER_DATA_I,
  input wire [7:0] SER_STATUS_I,
  input wire TIMER_BAUD_I,
  // selects toward the attached functions
  output wire [ROM_AW-1:0] ROM_ADDR_O,
  output wire ROM_SEL_O,
  output wire TIMER_SEL_O,
  output wire PAR_DATA_SEL_O,
  output wire PAR_STAT_SEL_O,
  output wire SER_DATA_SEL_O,
  output wire SER_STAT_SEL_O,
  // system memory gating
  output wire SYS_MEM_RD_EN_O,
  output wire SYS_MEM_WR_EN_O,
  // read answer from the card
  output reg [7:0] RD_DATA_O,
  output reg RD_VALID_O,
  // map state and serial bit clock
  output wire [1:0] MAP_STATE_O,
  output wire MAP_PENDING_O,
  output reg SER_BAUD_CLK_O
);

  // port match, used by every i/o select
  // exact compare; every i/o port decodes all eight address bits
  function io_hit;
    input [7:0] a;
    input [7:0] p;
    begin
      io_hit = (a == p);
    end
  endfunction

  // map state wires
  wire [1:0] map_q;
  wire grp0_off;
  wire grp1_off;
  wire ctrl_hit;
  wire ctrl_load;
  wire [1:0] ctrl_val;

  // memory window hits
  wire low_rom_win;
  wire high_rom_win;
  wire grp1_win;
  wire ram_win;
  wire timer_win;
  wire reserved_win;
  wire rom_hit;
  wire ram_hit;
  wire card_mem_hit;

  // group 1 pieces, all gated by the one control bit
  wire grp1_hit;
  wire timer_hit;
  wire reserved_hit;

  // i/o selects
  wire [7:0] io_a;
  wire io_any;
  wire par_alias;
  wire ser_alias;
  wire par_data_hit;
  wire par_stat_hit;
  wire ser_data_hit;
  wire ser_stat_hit;

  // scratch ram
  wire ram_we;
  wire [7:0] ram_rdata;

  // read answer pipeline
  reg [2:0] src_q;
  reg [2:0] src_d;
  reg pend_q;
  reg [7:0] rd_data_d;

  // where a read answer comes from, one code per attached part
  localparam [2:0] SRC_ROM = 3'd0;
  localparam [2:0] SRC_RAM = 3'd1;
  localparam [2:0] SRC_TIMER = 3'd2;
  localparam [2:0] SRC_PAR_DATA = 3'd3;
  localparam [2:0] SRC_PAR_STAT = 3'd4;
  localparam [2:0] SRC_SER_DATA = 3'd5;
  localparam [2:0] SRC_SER_STAT = 3'd6;
  localparam [2:0] SRC_IDLE = 3'd7;

  // control port decode
  assign io_a = ADDR_I[7:0];
  assign ctrl_hit = io_hit(io_a, `IO_MAP_CTRL);
  // a read of the control port is folded into a load of all ones,
  // so both groups drop out exactly as a write of c0 would
  // write-only control port
  assign ctrl_load = ctrl_hit & (IO_WR_I | IO_RD_I);
  assign ctrl_val = IO_RD_I ? `MAP_READ_VAL
                            : {DATA_I[`MAP_GRP1_BIT], DATA_I[`MAP_GRP0_BIT]};

  // the wait lets a three-byte jump after the write still come from
  // the old map; another control access during the wait starts over
  // delayed map change
  map_control u_map (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .load_i(ctrl_load),
    .load_val_i(ctrl_val),
    .cycle_i(CPU_CYCLE_I),
    .map_o(map_q),
    .pending_o(MAP_PENDING_O)
  );

  assign grp0_off = map_q[0];
  assign grp1_off = map_q[1];
  assign MAP_STATE_O = map_q;

  // memory windows from the upper address bits
  // five bits pick the 2K windows, longer compares pick ram and timers
  assign low_rom_win = (ADDR_I[15:11] == `LOW_ROM_TOP5);
  assign high_rom_win = (ADDR_I[15:11] == `HIGH_ROM_TOP5);
  assign grp1_win = (ADDR_I[15:12] == `GRP1_TOP4);
  assign ram_win = (ADDR_I[15:8] == `RAM_TOP8);
  assign timer_win = (ADDR_I[15:2] == `TIMER_TOP14);
  assign reserved_win = (ADDR_I[15:11] == `SHADOW_TOP5) & ~ram_win & ~timer_win;

  // group 1 claims the whole 4K page; the pieces inside it are
  // qualified by the same bit so they can never be split apart
  assign grp1_hit = grp1_win & ~grp1_off;
  assign timer_hit = timer_win & ~grp1_off;
  // the unused hole answers ff so a stray read never reaches the bus
  assign reserved_hit = reserved_win & ~grp1_off;

  assign rom_hit = (low_rom_win & ~grp0_off) | (high_rom_win & ~grp1_off);
  assign ram_hit = ram_win & ~grp1_off;
  assign card_mem_hit = rom_hit | grp1_hit;

  // 1K part repeats in both halves
  // same offset both windows
  // a 1K part has no top address line, so it shows up twice
  assign ROM_ADDR_O = {ADDR_I[ROM_AW-1] & ~ROM_1K_I, ADDR_I[ROM_AW-2:0]};
  assign ROM_SEL_O = MEM_RD_I & rom_hit;
  assign TIMER_SEL_O = (MEM_RD_I | MEM_WR_I) & timer_hit;

  // card hides system memory on reads
  // reads from the rom window
  // reads in an enabled window never reach system memory
  assign SYS_MEM_RD_EN_O = MEM_RD_I & ~card_mem_hit;

  // rom windows pass writes
  // writes under the rom windows still land in system memory, so a
  // loader running from rom can fill the whole space; only the
  // group 1 page below the high rom window is blocked
  assign SYS_MEM_WR_EN_O = MEM_WR_I & ~(grp1_hit & ~high_rom_win);

  // ram written only while group 1 is on; hidden memory untouched
  // ram array keeps contents
  assign ram_we = MEM_WR_I & ram_hit;
  scratch_ram #(
    .AW(RAM_AW),
    .DW(8)
  ) u_ram (
    .clk_i(CORE_CLK_I),
    .we_i(ram_we),
    .addr_i(ADDR_I[RAM_AW-1:0]),
    .wdata_i(DATA_I),
    .rdata_o(ram_rdata)
  );

  // i/o port selects
  assign io_any = IO_RD_I | IO_WR_I;
  // with both switches on the parallel port keeps 02/03; the serial
  // side loses them rather than two parts driving one read
  // parallel takes 02/03 if both are on
  assign par_alias = PAR_CONSOLE_ALIAS_I;
  assign ser_alias = SER_CONSOLE_ALIAS_I & ~PAR_CONSOLE_ALIAS_I;

  assign par_data_hit = io_hit(io_a, `IO_PAR_DATA) |
                        (par_alias & io_hit(io_a, `IO_ALIAS_DATA));
  assign par_stat_hit = io_hit(io_a, `IO_PAR_STAT) |
                        (par_alias & io_hit(io_a, `IO_ALIAS_STAT));

  assign ser_data_hit = io_hit(io_a, `IO_SER_DATA) |
                        io_hit(io_a, `IO_SER_DATA2) |
                        (ser_alias & io_hit(io_a, `IO_ALIAS_DATA));
  assign ser_stat_hit = io_hit(io_a, `IO_SER_STAT) |
                        io_hit(io_a, `IO_SER_STAT2) |
                        (ser_alias & io_hit(io_a, `IO_ALIAS_STAT));

  // a select only fires for an actual i/o strobe
  assign PAR_DATA_SEL_O = io_any & par_data_hit;
  assign PAR_STAT_SEL_O = io_any & par_stat_hit;
  assign SER_DATA_SEL_O = io_any & ser_data_hit;
  assign SER_STAT_SEL_O = io_any & ser_stat_hit;

  // pick the source of a read in its strobe cycle
  always @* begin
    src_d = SRC_IDLE;
    if (MEM_RD_I) begin
      if (rom_hit) begin
        src_d = SRC_ROM;
      end else if (ram_hit) begin
        src_d = SRC_RAM;
      end else if (timer_hit) begin
        src_d = SRC_TIMER;
      end else if (reserved_hit) begin
        // hole in group 1 space: answered, but with idle data
        src_d = SRC_IDLE;
      end
    end else if (IO_RD_I) begin
      if (par_data_hit) begin
        src_d = SRC_PAR_DATA;
      end else if (par_stat_hit) begin
        src_d = SRC_PAR_STAT;
      end else if (ser_data_hit) begin
        src_d = SRC_SER_DATA;
      end else if (ser_stat_hit) begin
        src_d = SRC_SER_STAT;
      end
    end
  end

  // remember the source; the ram answers one edge later
  // pend_q marks reads the card answers; system memory reads get none
  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      src_q <= SRC_IDLE;
      pend_q <= 1'b0;
    end else begin
      src_q <= src_d;
      pend_q <= MEM_RD_I & card_mem_hit | IO_RD_I;
    end
  end

  // answer mux; reserved group 1 space and control port read ff
  always @* begin
    case (src_q)
      SRC_ROM: rd_data_d = ROM_DATA_I;
      SRC_RAM: rd_data_d = ram_rdata;
      SRC_TIMER: rd_data_d = TIMER_DATA_I;
      SRC_PAR_DATA: rd_data_d = PAR_DATA_I;
      // status bits 7 and 6 share position and meaning with the
      // control port, so a read value can be written straight back
      // group state in status byte
      SRC_PAR_STAT: rd_data_d = {grp1_off, grp0_off, PAR_STATUS_I};
      SRC_SER_DATA: rd_data_d = SER_DATA_I;
      SRC_SER_STAT: rd_data_d = SER_STATUS_I;
      default: rd_data_d = `IDLE_READ;
    endcase
  end

  // read data held in flip-flops, valid for one cycle
  // data holds between answers so a slow reader still sees it
  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      RD_DATA_O <= `IDLE_READ;
      RD_VALID_O <= 1'b0;
    end else begin
      RD_VALID_O <= pend_q;
      if (pend_q) begin
        RD_DATA_O <= rd_data_d;
      end
    end
  end

  // bit clock from timer channel
  // registered so the serial side sees a clean level
  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      SER_BAUD_CLK_O <= 1'b0;
    end else begin
      SER_BAUD_CLK_O <= TIMER_BAUD_I;
    end
  end

endmodule

`default_nettype wire

// file: verif/memory_port_decode_checker.sv
`timescale 1ns/1ps
`default_nettype none
module memory_port_decode_checker #(
  parameter ROM_AW = 11
) (
  // clock, reset, cycles
  input wire logic CORE_CLK_I, RST_I,
  input wire logic [15:0] ADDR_I,
  input wire logic MEM_RD_I, MEM_WR_I, IO_RD_I, IO_WR_I,
  input wire logic PAR_CONSOLE_ALIAS_I, ROM_1K_I,
  input wire logic [5:0] PAR_STATUS_I,
  // design outputs
  input wire logic [ROM_AW-1:0] ROM_ADDR_O,
  input wire logic ROM_SEL_O, PAR_STAT_SEL_O, SER_STAT_SEL_O,
  input wire logic SYS_MEM_RD_EN_O, SYS_MEM_WR_EN_O,
  input wire logic [7:0] RD_DATA_O,
  input wire logic RD_VALID_O,
  input wire logic [1:0] MAP_STATE_O,
  input wire logic MAP_PENDING_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  // single-cycle accesses
  sequence ctl_wr; IO_WR_I && ADDR_I[7:0] == 8'hf3; endsequence
  sequence ctl_rd; IO_RD_I && ADDR_I[7:0] == 8'hf3; endsequence
  sequence stat_rd; IO_RD_I && ADDR_I[7:0] == 8'h15; endsequence
  par_fix_a: assert property (stat_rd |-> PAR_STAT_SEL_O) else $error("par stat sel");
  par_alias_a: assert property (
    IO_RD_I && PAR_CONSOLE_ALIAS_I && ADDR_I[7:0] == 8'h03
    |-> PAR_STAT_SEL_O && !SER_STAT_SEL_O) else $error("par alias sel");
  ser_fix_a: assert property (
    IO_RD_I && (ADDR_I[7:0] == 8'h13 || ADDR_I[7:0] == 8'h05)
    |-> SER_STAT_SEL_O) else $error("ser stat sel");
  rom_low_a: assert property (
    MEM_RD_I && ADDR_I[15:11] == 5'h00 && !MAP_STATE_O[0]
    |-> ROM_SEL_O && !SYS_MEM_RD_EN_O) else $error("low rom read");
  shadow_wr_a: assert property (
    MEM_WR_I && ADDR_I[15:11] == 5'h1a && !MAP_STATE_O[1]
    |-> !SYS_MEM_WR_EN_O) else $error("shadow write");
  rom_wr_a: assert property (
    MEM_WR_I && ADDR_I[15:11] == 5'h1b
    |-> SYS_MEM_WR_EN_O) else $error("rom write pass");
  rom_mirror_a: assert property (
    ROM_SEL_O && ROM_1K_I
    |-> !ROM_ADDR_O[10]) else $error("rom mirror");
  stat_data_a: assert property (
    stat_rd |-> ##2 RD_VALID_O && RD_DATA_O[5:0] == $past(PAR_STATUS_I, 1)
    && RD_DATA_O[7:6] == $past(MAP_STATE_O, 1)) else $error("status data");
  map_wait_a: assert property (ctl_wr |=> MAP_PENDING_O[*2]) else $error("map wait");
  map_hold_a: assert property (MAP_PENDING_O |-> $stable(MAP_STATE_O)) else $error("map hold");
  ctl_rd_a: assert property (ctl_rd |-> ##2 RD_DATA_O == 8'hff) else $error("ctl read");
endmodule
bind memory_port_decode memory_port_decode_checker #(.ROM_AW(ROM_AW)) chk (
  .CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .MEM_RD_I(MEM_RD_I),
  .MEM_WR_I(MEM_WR_I), .IO_RD_I(IO_RD_I), .IO_WR_I(IO_WR_I),
  .PAR_CONSOLE_ALIAS_I(PAR_CONSOLE_ALIAS_I), .ROM_1K_I(ROM_1K_I),
  .PAR_STATUS_I(PAR_STATUS_I), .ROM_ADDR_O(ROM_ADDR_O), .ROM_SEL_O(ROM_SEL_O),
  .PAR_STAT_SEL_O(PAR_STAT_SEL_O), .SER_STAT_SEL_O(SER_STAT_SEL_O),
  .SYS_MEM_RD_EN_O(SYS_MEM_RD_EN_O), .SYS_MEM_WR_EN_O(SYS_MEM_WR_EN_O),
  .RD_DATA_O(RD_DATA_O), .RD_VALID_O(RD_VALID_O), .MAP_STATE_O(MAP_STATE_O),
  .MAP_PENDING_O(MAP_PENDING_O));
`default_nettype wire

// file: verif/cpu_side_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_side_model (
  input wire logic clk_i,
  input wire logic rom_sel_i,
  input wire logic par_stat_sel_i,
  input wire logic [10:0] rom_addr_i,
  output logic cycle_o,
  output logic baud_o,
  output logic [7:0] rom_data_o,
  output logic [7:0] misc_data_o,
  output logic [5:0] par_stat_o
);
  logic [1:0] div_q = 2'h0;
  // machine cycle every fourth clock, baud from a timer output
  always @(posedge clk_i) begin
    div_q <= #1 div_q + 2'h1;
    cycle_o <= #1 (div_q == 2'h3);
    baud_o <= #1 div_q[1];
    misc_data_o <= #1 {div_q, ~div_q, div_q, ~div_q};
    // unselected parts show a toggling pattern, never a stale byte
    rom_data_o <= #1 rom_sel_i ? (rom_addr_i[7:0] ^ {5'h00, rom_addr_i[10:8]} ^ 8'h5a)
      : ~rom_data_o;
    par_stat_o <= #1 par_stat_sel_i ? 6'h2d : ~par_stat_o;
  end
endmodule
`default_nettype wire

// file: verif/memory_port_decode_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module memory_port_decode_test;
  logic clk = 0, rst = 1, mrd = 0, mwr = 0, iord = 0, iowr = 0, cyc, baud;
  logic palias = 0, salias = 0, r1k = 0, v, se_rd, se_wr, ps, ss, pend, rsel;
  logic pd, sd, ts, crd, cwr, pds, sds, tsel, bclk, b;
  logic [15:0] addr = 16'h0000;
  logic [7:0] din = 8'h00, r, rom_d, misc_d, rdo, r2;
  logic [5:0] pstat;
  logic [1:0] map;
  logic [10:0] rom_a;
  integer n_errors = 0, check_count = 0, cycles = 0, npulse = 0, lf = 72969, i, a;
  integer ram_m [0:255];
  wire pss, sss;
  always #2.5 clk = ~clk;
  memory_port_decode uut (.CORE_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .DATA_I(din),
    .MEM_RD_I(mrd), .MEM_WR_I(mwr), .IO_RD_I(iord), .IO_WR_I(iowr), .CPU_CYCLE_I(cyc),
    .PAR_CONSOLE_ALIAS_I(palias), .SER_CONSOLE_ALIAS_I(salias), .ROM_1K_I(r1k),
    .ROM_DATA_I(rom_d), .TIMER_DATA_I(misc_d), .PAR_DATA_I(misc_d), .PAR_STATUS_I(pstat),
    .SER_DATA_I(misc_d), .SER_STATUS_I(~misc_d), .TIMER_BAUD_I(baud), .ROM_ADDR_O(rom_a),
    .ROM_SEL_O(rsel), .TIMER_SEL_O(tsel), .PAR_DATA_SEL_O(pds), .PAR_STAT_SEL_O(pss),
    .SER_DATA_SEL_O(sds), .SER_STAT_SEL_O(sss), .SYS_MEM_RD_EN_O(se_rd),
    .SYS_MEM_WR_EN_O(se_wr), .RD_DATA_O(rdo), .RD_VALID_O(v), .MAP_STATE_O(map),
    .MAP_PENDING_O(pend), .SER_BAUD_CLK_O(bclk));
  cpu_side_model far (.clk_i(clk), .rom_sel_i(rsel), .par_stat_sel_i(pss), .rom_addr_i(rom_a),
    .cycle_o(cyc), .baud_o(baud), .rom_data_o(rom_d), .misc_data_o(misc_d), .par_stat_o(pstat));
  function automatic integer nxt(input integer s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic [7:0] rom_f(input [10:0] x);
    rom_f = x[7:0] ^ {5'h00, x[10:8]} ^ 8'h5a;
  endfunction
  // count machine cycles while a map change waits
  always @(posedge clk) begin
    cycles++;
    if (pend === 1'b1 && cyc === 1'b1) npulse++;
    if (cycles == 20000) begin
      n_errors++;
      close_out;
    end
  end
  // one access: kind 0 mem rd, 1 mem wr, 2 io rd, 3 io wr
  task acc(input [1:0] k, input [15:0] ad, input [7:0] d);
    @(posedge clk);
    #1 {iowr, iord, mwr, mrd} = 4'h1 << k;
    addr = ad;
    din = d;
    #1 {ps, ss, pd, sd, ts, crd, cwr} = {pss, sss, pds, sds, tsel, se_rd, se_wr};
    @(posedge clk);
    #1 {iowr, iord, mwr, mrd} = 4'h0;
    r = 8'h00;
    repeat (3) begin
      @(posedge clk);
      #1 if (v === 1'b1) r = rdo;
    end
  endtask
  // wait for a commanded map to land
  task wmap(input [1:0] e, input p);
    for (i = 0; i < 60 && pend !== 1'b0; i++) @(posedge clk);
    #1 `CHK("map", e, map)
    if (p) `CHK("cycles", 3, npulse)
  endtask
  task setmap(input [7:0] d, input p);
    npulse = 0;
    acc(3, 16'h00f3, d);
    wmap(d[7:6], p);
  endtask
  task close_out;
    if (n_errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1 rst = 0;
    `CHK("reset map", 2'b00, map)
    acc(2, 16'h0015, 8'h00);
    `CHK("status", 8'h2d, r)
    acc(0, 16'h01e4, 8'h00);
    r2 = r;
    acc(0, 16'hd9e4, 8'h00);
    `CHK("rom low", rom_f(11'h1e4), r2)
    `CHK("rom high", r2, r)
    r1k = 1;
    acc(0, 16'h05e4, 8'h00);
    `CHK("rom 1k", rom_f(11'h1e4), r)
    r1k = 0;
    // scratch ram at random offsets, data from the lfsr
    for (a = 0; a < 256; a++) ram_m[a] = -1;
    repeat (8) begin
      lf = nxt(lf);
      ram_m[lf[7:0]] = lf[15:8];
      acc(1, {8'hd0, lf[7:0]}, lf[15:8]);
      `CHK("ram hides sys", 1'b0, cwr)
    end
    for (a = 0; a < 4; a++) begin
      lf = nxt(lf);
      setmap({a[1:0], lf[5:0]}, 1);
      acc(0, 16'h0000, 8'h00);
      `CHK("low sys rd", a[0], crd)
      acc(0, 16'hd800, 8'h00);
      `CHK("high sys rd", a[1], crd)
      acc(1, 16'hd400, 8'h00);
      `CHK("shadow wr", a[1], cwr)
      acc(1, 16'h0100, 8'h00);
      `CHK("rom wr pass", 1'b1, cwr)
      acc(1, 16'hd0ff, 8'h00);
      `CHK("ram sys wr", a[1], cwr)
      if (a == 2) `CHK("all wr", 1'b1, cwr)
      acc(1, 16'hd900, 8'h00);
      `CHK("hi rom wr", 1'b1, cwr)
      if (!a[1]) ram_m[255] = 0;
    end
    acc(2, 16'h0015, 8'h00);
    `CHK("status off", 8'hed, r)
    setmap(r, 0);
    `CHK("write back", 2'b11, map)
    setmap(8'h00, 1);
    for (a = 0; a < 256; a++) if (ram_m[a] >= 0) begin
      acc(0, {8'hd0, a[7:0]}, 8'h00);
      `CHK("ram kept", ram_m[a][7:0], r)
    end
    acc(1, 16'hd101, lf[7:0]);
    `CHK("timer sel", 2'b10, {ts, cwr})
    acc(2, 16'h0014, 8'h00);
    `CHK("par data sel", 2'b10, {pd, sd})
    acc(2, 16'h0012, 8'h00);
    `CHK("ser data sel", 2'b01, {pd, sd})
    // bit clock is the timer level one edge later
    repeat (4) begin
      @(posedge clk);
      #2 b = baud;
      @(posedge clk);
      #2 `CHK("baud", b, bclk)
    end
    npulse = 0;
    acc(2, 16'h00f3, 8'h00);
    `CHK("ctl read", 8'hff, r)
    wmap(2'b11, 1);
    acc(1, 16'hd101, 8'h00);
    `CHK("timer off", 2'b01, {ts, cwr})
    acc(0, 16'hd010, 8'h00);
    `CHK("ram off rd", 1'b1, crd)
    // alias switches, never both at once
    // one alias switch
    palias = 1;
    acc(2, 16'h0003, 8'h00);
    `CHK("par alias sel", 1'b1, ps)
    `CHK("par alias data", 8'hed, r)
    palias = 0;
    salias = 1;
    acc(2, 16'h0003, 8'h00);
    `CHK("ser alias sel", 2'b01, {ps, ss})
    acc(2, 16'h0005, 8'h00);
    `CHK("ser 05 sel", 1'b1, ss)
    @(posedge clk);
    #1 rst = 1;
    repeat (2) @(posedge clk);
    #1 rst = 0;
    `CHK("rerun map", 2'b00, map)
    close_out;
  end
endmodule
`default_nettype wire
